// ===== logic/stf_pkg.sv
// Package of the task-file command front end: register selects, status
// field positions, command codes, time limits and the received frame layout.
// Assumes a single 40 MHz clock.
package stf_pkg;

   // ==================================================================
   // Clock and time base
   localparam int unsigned STF_CLK_HZ        = 40_000_000;
   localparam int unsigned STF_MS_PER_S      = 1000;
   localparam int unsigned STF_CYCLES_PER_MS = STF_CLK_HZ / STF_MS_PER_S;

   // ==================================================================
   // Time limits, in their printed units
   localparam int unsigned STF_POR_WINDOW_MS    = 500;
   localparam int unsigned STF_COMINIT_MAX_MS   = 10;
   localparam int unsigned STF_STREAM_MIN_MS    = 50;
   localparam int unsigned STF_STREAM_MIN_LP_MS = 100;
   // Recovery minimums in tenths of a second (6.5 s and 0.3 s)
   localparam int unsigned STF_RECOV_MIN_DS     = 65;
   localparam int unsigned STF_RECOV_MIN_LP_DS  = 3;
   localparam int unsigned STF_MS_PER_DS        = 100;
   localparam int unsigned STF_RECOV_MIN_MS     = STF_RECOV_MIN_DS * STF_MS_PER_DS;
   localparam int unsigned STF_RECOV_MIN_LP_MS  = STF_RECOV_MIN_LP_DS * STF_MS_PER_DS;
   localparam int unsigned STF_LIMIT_W          = 16;

   // ==================================================================
   // Read selects of the task-file read port
   localparam logic [1:0] STF_SEL_STATUS     = 2'h0;
   localparam logic [1:0] STF_SEL_ALT_STATUS = 2'h1;
   localparam logic [1:0] STF_SEL_SECT_CNT   = 2'h2;
   localparam logic [1:0] STF_SEL_ERROR      = 2'h3;

   // ==================================================================
   // Status bit positions (primary and mirror alike)
   localparam int unsigned STF_ST_BUSY  = 7;
   localparam int unsigned STF_ST_READY = 6;
   localparam int unsigned STF_ST_FAULT = 5;
   localparam int unsigned STF_ST_SEEK  = 4;
   localparam int unsigned STF_ST_DRQ   = 3;
   localparam int unsigned STF_ST_CORR  = 2;
   localparam int unsigned STF_ST_INDEX = 1;
   localparam int unsigned STF_ST_ERR   = 0;

   // Device control soft reset bit, error register abort bit
   localparam int unsigned STF_DC_SOFT_RESET = 2;
   localparam logic [7:0]  STF_ERR_ABORT     = 8'h04;
   localparam logic [7:0]  STF_ERR_DIAG_OK   = 8'h01;

   // ==================================================================
   // Command codes and reply values
   localparam logic [7:0] STF_CMD_CHECK_POWER  = 8'hE5;
   localparam logic [7:0] STF_CMD_DOWNLOAD     = 8'h92;
   localparam logic [7:0] STF_CMD_READ_STREAM  = 8'h2A;
   localparam logic [7:0] STF_CMD_WRITE_STREAM = 8'h3A;
   localparam logic [7:0] STF_CMD_SCT_RECOVERY = 8'hB0;
   localparam logic [7:0] STF_PWR_IDLE         = 8'hFF;
   localparam logic [7:0] STF_PWR_IDLE_ALT     = 8'h80;
   localparam logic [7:0] STF_PWR_STANDBY      = 8'h00;

   // ==================================================================
   // Register frame received from the host adapter
   typedef struct packed {
      logic                   isCommand;
      logic [7:0]             command;
      logic [7:0]             features;
      logic [7:0]             sectorCount;
      logic [STF_LIMIT_W-1:0] limitMs;
      logic [7:0]             devControl;
   } stf_frame_type;

   typedef enum logic [1:0] {KIND_OTHER, KIND_STREAM, KIND_RECOVERY} stf_kind_type;

endpackage

// ===== logic/stf_ms_timer.sv
// Millisecond countdown timer: loads a count, steps down on each tick, holds at zero.
// Assumes the tick is a one-cycle enable from a divider in the same domain.
`timescale 1ns/1ps
`default_nettype none
module stf_ms_timer #(
   parameter int unsigned WIDTH = 16
) (
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             sys_rst,
   // Control
   input  wire logic             tick,
   input  wire logic             load,
   input  wire logic [WIDTH-1:0] loadValue,
   // Result
   output var  logic             expired
);

   logic [WIDTH-1:0] count;
   logic [WIDTH-1:0] next_count;

   // ==================================================================
   // Next count
   always_comb begin
      next_count = count;
      if (load) begin
         next_count = loadValue;
      end else if (tick && (count != '0)) begin
         next_count = count - WIDTH'(1);
      end
   end

   // Registers; expired reflects the count about to be held
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         count   <= '0;
         expired <= 1'b1;
      end else begin
         count   <= next_count;
         expired <= (next_count == '0);
      end
   end

endmodule // stf_ms_timer
`default_nettype wire

// ===== logic/stf_front_end.sv
// Task-file command front end of a serial disk device: takes register
// frames, runs command launch, status and reset replies.
// Assumes frames, reads and media signals are synchronous to clk.
//
// Summary of operation
// - Idle power query returns FFh in sector count, never 80h.
// - Firmware download is aborted while security is locked.
// - Link reset reply may come late in first 500ms after power-on.
// - Streaming command in standby waits for spin-up despite its limit.
// - Streaming limit is at least 50ms; shorter requests become 50ms.
// - Low-power variants use 100ms as streaming limit minimum.
// - Recovery-limited command in standby waits for spin-up despite limit.
// - Recovery limit below 6.5 s aborts the command.
// - Low-power variants use 0.3 s as recovery limit minimum.
// - Mirror status shows the same eight bits as primary status.
// - Mirror read never acknowledges the pending interrupt.
// - Command starts as soon as its code arrives.
`timescale 1ns/1ps
`default_nettype none
module stf_front_end
   import stf_pkg::*;
#(
   parameter int unsigned MS_CYCLES = STF_CYCLES_PER_MS
) (
   // Clock and reset
   input  wire logic          clk,
   input  wire logic          sys_rst,
   // Frames and link reset from the host adapter
   input  wire logic          frameValid,
   input  wire stf_frame_type frame,
   input  wire logic          comResetReq,
   output var  logic          comInit,
   // Drive condition
   input  wire logic          standbyMode,
   input  wire logic          spinReady,
   input  wire logic          securityLocked,
   input  wire logic          lowPowerModel,
   input  wire logic          driveFault,
   input  wire logic          seekDone,
   input  wire logic          dataRequest,
   input  wire logic          correctedData,
   input  wire logic          indexPulse,
   // Media engine
   output var  logic          cmdStart,
   output var  logic [7:0]    cmdCode,
   output var  logic [15:0]   effLimitMs,
   input  wire logic          mediaDone,
   input  wire logic          mediaError,
   // Task-file read port
   input  wire logic          rdEn,
   input  wire logic [1:0]    rdSel,
   output var  logic [7:0]    readData,
   output var  logic [7:0]    status,
   output var  logic [7:0]    sectorCountOut,
   output var  logic [7:0]    errorOut,
   output var  logic          intPending
);

   typedef enum logic [1:0] {ST_IDLE, ST_SPINUP, ST_EXEC, ST_RESET} stf_state_type;

   // Effective streaming limit, raised to the model minimum
   function automatic logic [15:0] streamLimit(input logic [15:0] req, input logic lp);
      logic [15:0] floorMs;
      floorMs = lp ? 16'(STF_STREAM_MIN_LP_MS) : 16'(STF_STREAM_MIN_MS);
      return (req < floorMs) ? floorMs : req;
   endfunction

   // Recovery limit below the model minimum
   function automatic logic recovTooShort(input logic [15:0] req, input logic lp);
      return req < (lp ? 16'(STF_RECOV_MIN_LP_MS) : 16'(STF_RECOV_MIN_MS));
   endfunction

   // ==================================================================
   // Millisecond divider
   logic [31:0] divCount;
   logic [31:0] next_divCount;
   logic        msTick;

   always_comb begin
      next_divCount = (divCount == 32'(MS_CYCLES - 1)) ? 32'h0 : divCount + 32'h1;
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         divCount <= 32'h0;
         msTick   <= 1'b0;
      end else begin
         divCount <= next_divCount;
         msTick   <= (next_divCount == 32'h0);
      end
   end

   // ==================================================================
   // Power-on window and link reset reply
   logic porArm;
   logic porExpired;
   logic porWindow;
   logic resetPend;
   logic next_resetPend;
   logic next_comInit;

   stf_ms_timer #(.WIDTH(16)) porTimer (
      .clk       (clk),
      .sys_rst   (sys_rst),
      .tick      (msTick),
      .load      (porArm),
      .loadValue (16'(STF_POR_WINDOW_MS)),
      .expired   (porExpired)
   );

   assign porWindow = porArm || !porExpired;

   // Reply at once, or hold the reply until the window closes
   always_comb begin
      next_resetPend = resetPend;
      next_comInit   = 1'b0;
      if (comResetReq && !porWindow) begin
         next_comInit   = 1'b1;
         next_resetPend = 1'b0;
      end else if (comResetReq) begin
         next_resetPend = 1'b1;
      end else if (resetPend && !porWindow) begin
         next_comInit   = 1'b1;
         next_resetPend = 1'b0;
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         porArm    <= 1'b1;
         resetPend <= 1'b0;
         comInit   <= 1'b0;
      end else begin
         porArm    <= 1'b0;
         resetPend <= next_resetPend;
         comInit   <= next_comInit;
      end
   end

   // ==================================================================
   // Command state
   stf_state_type state,        next_state;
   stf_kind_type  kind,         next_kind;
   logic          busy,         next_busy;
   logic          errBit,       next_errBit;
   logic          softReset,    next_softReset;
   logic          intSet;
   logic [7:0]    next_sectorCountOut;
   logic [7:0]    next_errorOut;
   logic [7:0]    next_cmdCode;
   logic [15:0]   next_effLimitMs;
   logic          next_cmdStart;
   logic          timerLoad;
   logic          limitExpired;
   logic          next_intPending;

   stf_ms_timer #(.WIDTH(16)) limitTimer (
      .clk       (clk),
      .sys_rst   (sys_rst),
      .tick      (msTick),
      .load      (timerLoad),
      .loadValue (next_effLimitMs),
      .expired   (limitExpired)
   );

   // Frame decode, launch and completion
   always_comb begin
      next_state          = state;
      next_kind           = kind;
      next_busy           = busy;
      next_errBit         = errBit;
      next_softReset      = softReset;
      next_sectorCountOut = sectorCountOut;
      next_errorOut       = errorOut;
      next_cmdCode        = cmdCode;
      next_effLimitMs     = effLimitMs;
      next_cmdStart       = 1'b0;
      timerLoad           = 1'b0;
      intSet              = 1'b0;
      if (comResetReq) begin
         next_state     = ST_IDLE;
         next_busy      = 1'b0;
         next_errBit    = 1'b0;
         next_softReset = 1'b0;
         next_errorOut  = STF_ERR_DIAG_OK;
      end else if (frameValid && !frame.isCommand) begin
         // Only a change of soft reset arrives; a repeat would still clear busy and the error like a change
         next_softReset = frame.devControl[STF_DC_SOFT_RESET];
         next_state     = next_softReset ? ST_RESET : ST_IDLE;
         next_busy      = 1'b0;
         next_errBit    = 1'b0;
         next_errorOut  = STF_ERR_DIAG_OK;
      end else if (frameValid && (state == ST_IDLE)) begin
         // Parameters already stand in the frame with the code
         next_cmdCode  = frame.command;
         next_busy     = 1'b1;
         next_errBit   = 1'b0;
         next_errorOut = 8'h00;
         next_kind     = KIND_OTHER;
         case (frame.command)
            STF_CMD_CHECK_POWER: begin
               next_sectorCountOut = standbyMode ? STF_PWR_STANDBY : STF_PWR_IDLE;
               next_busy           = 1'b0;
               intSet              = 1'b1;
            end
            STF_CMD_DOWNLOAD: begin
               if (securityLocked) begin
                  next_busy     = 1'b0;
                  next_errBit   = 1'b1;
                  next_errorOut = STF_ERR_ABORT;
                  intSet        = 1'b1;
               end else begin
                  next_state    = ST_EXEC;
                  next_cmdStart = 1'b1;
               end
            end
            STF_CMD_READ_STREAM, STF_CMD_WRITE_STREAM: begin
               next_kind       = KIND_STREAM;
               next_effLimitMs = streamLimit(frame.limitMs, lowPowerModel);
               timerLoad       = 1'b1;
               next_state      = standbyMode ? ST_SPINUP : ST_EXEC;
               next_cmdStart   = !standbyMode;
            end
            STF_CMD_SCT_RECOVERY: begin
               next_kind = KIND_RECOVERY;
               if (recovTooShort(frame.limitMs, lowPowerModel)) begin
                  next_busy     = 1'b0;
                  next_errBit   = 1'b1;
                  next_errorOut = STF_ERR_ABORT;
                  intSet        = 1'b1;
               end else begin
                  next_effLimitMs = frame.limitMs;
                  timerLoad       = 1'b1;
                  next_state      = standbyMode ? ST_SPINUP : ST_EXEC;
                  next_cmdStart   = !standbyMode;
               end
            end
            default: begin
               next_state    = ST_EXEC;
               next_cmdStart = 1'b1;
            end
         endcase
      end else begin
         case (state)
            ST_SPINUP: begin
               // Limit expiry is ignored until the spindle is at speed
               if (spinReady) begin
                  next_state    = ST_EXEC;
                  next_cmdStart = 1'b1;
               end
            end
            ST_EXEC: begin
               if (mediaDone || ((kind == KIND_STREAM) && limitExpired)) begin
                  next_state    = ST_IDLE;
                  next_busy     = 1'b0;
                  next_errBit   = mediaDone && mediaError;
                  next_errorOut = (mediaDone && mediaError) ? STF_ERR_ABORT : 8'h00;
                  intSet        = 1'b1;
               end
            end
            ST_RESET: begin
               next_busy = 1'b0;
            end
            default: begin
               next_state = ST_IDLE;
            end
         endcase
      end
   end

   // Interrupt: completion set wins over a primary status read
   always_comb begin
      next_intPending = intPending;
      if (rdEn && (rdSel == STF_SEL_STATUS)) begin
         next_intPending = 1'b0;
      end
      if (intSet) begin
         next_intPending = 1'b1;
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         state          <= ST_IDLE;
         kind           <= KIND_OTHER;
         busy           <= 1'b0;
         errBit         <= 1'b0;
         softReset      <= 1'b0;
         sectorCountOut <= 8'h00;
         errorOut       <= STF_ERR_DIAG_OK;
         cmdCode        <= 8'h00;
         effLimitMs     <= 16'h0000;
         cmdStart       <= 1'b0;
         intPending     <= 1'b0;
      end else begin
         state          <= next_state;
         kind           <= next_kind;
         busy           <= next_busy;
         errBit         <= next_errBit;
         softReset      <= next_softReset;
         sectorCountOut <= next_sectorCountOut;
         errorOut       <= next_errorOut;
         cmdCode        <= next_cmdCode;
         effLimitMs     <= next_effLimitMs;
         cmdStart       <= next_cmdStart;
         intPending     <= next_intPending;
      end
   end

   // ==================================================================
   // Status byte and read port
   logic [7:0] next_status;
   logic [7:0] next_readData;

   always_comb begin
      next_status               = 8'h00;
      next_status[STF_ST_BUSY]  = next_busy;
      next_status[STF_ST_READY] = !next_softReset;
      next_status[STF_ST_FAULT] = driveFault;
      next_status[STF_ST_SEEK]  = seekDone;
      next_status[STF_ST_DRQ]   = dataRequest;
      next_status[STF_ST_CORR]  = correctedData;
      next_status[STF_ST_INDEX] = indexPulse;
      next_status[STF_ST_ERR]   = next_errBit;
      case (rdSel)
         STF_SEL_STATUS:     next_readData = status;
         STF_SEL_ALT_STATUS: next_readData = status;
         STF_SEL_SECT_CNT:   next_readData = sectorCountOut;
         default:            next_readData = errorOut;
      endcase
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         status   <= 8'h40;
         readData <= 8'h00;
      end else begin
         status   <= next_status;
         readData <= rdEn ? next_readData : readData;
      end
   end

   // ==================================================================
   // Checks
   sequence s_idleCmd(logic [7:0] code, logic cond);
      frameValid && frame.isCommand && (frame.command == code) && (state == ST_IDLE)
         && !comResetReq && cond;
   endsequence

   property p_powerIdle;
      @(posedge clk) disable iff (sys_rst)
      s_idleCmd(STF_CMD_CHECK_POWER, !standbyMode) |=> (sectorCountOut == 8'hFF) && !busy;
   endproperty
   a_powerIdle: assert property (p_powerIdle) else $error("power query idle reply wrong");

   property p_never80;
      @(posedge clk) disable iff (sys_rst) sectorCountOut != STF_PWR_IDLE_ALT;
   endproperty
   a_never80: assert property (p_never80) else $error("sector count shows 80h");

   property p_dlAbort;
      @(posedge clk) disable iff (sys_rst)
      s_idleCmd(STF_CMD_DOWNLOAD, securityLocked) |=> errBit && !busy && status[STF_ST_ERR]
         && !status[STF_ST_BUSY] ##1 status[STF_ST_ERR] && !status[STF_ST_BUSY];
   endproperty
   a_dlAbort: assert property (p_dlAbort) else $error("locked download not aborted");

   property p_comInitLate;
      @(posedge clk) disable iff (sys_rst)
      comResetReq && !porWindow |=> comInit;
   endproperty
   a_comInitLate: assert property (p_comInitLate) else $error("link reset reply missing");

   property p_spinWait;
      @(posedge clk) disable iff (sys_rst)
      (state == ST_SPINUP) && !spinReady && !comResetReq && !frameValid |=> busy && !cmdStart;
   endproperty
   a_spinWait: assert property (p_spinWait) else $error("completed before spin-up");

   property p_streamFloor;
      @(posedge clk) disable iff (sys_rst)
      (kind == KIND_STREAM) && (state == ST_EXEC)
         |-> effLimitMs >= (lowPowerModel ? 16'd100 : 16'd50);
   endproperty
   a_streamFloor: assert property (p_streamFloor) else $error("streaming limit under floor");

   property p_recovAbort;
      @(posedge clk) disable iff (sys_rst)
      s_idleCmd(STF_CMD_SCT_RECOVERY, frame.limitMs < (lowPowerModel ? 16'd300 : 16'd6500))
         |=> errBit && !busy && (errorOut == 8'h04);
   endproperty
   a_recovAbort: assert property (p_recovAbort) else $error("short recovery limit accepted");

   property p_altSame;
      @(posedge clk) disable iff (sys_rst)
      rdEn && (rdSel == STF_SEL_ALT_STATUS) |=> readData == $past(status);
   endproperty
   a_altSame: assert property (p_altSame) else $error("mirror status differs");

   property p_altNoAck;
      @(posedge clk) disable iff (sys_rst)
      rdEn && (rdSel == STF_SEL_ALT_STATUS) && intPending |=> intPending;
   endproperty
   a_altNoAck: assert property (p_altNoAck) else $error("mirror read cleared interrupt");

   property p_launch;
      @(posedge clk) disable iff (sys_rst)
      s_idleCmd(8'h20, 1'b1) |=> busy && cmdStart;
   endproperty
   a_launch: assert property (p_launch) else $error("command did not start");

endmodule // stf_front_end
`default_nettype wire

// ===== sim/stf_host_model.sv
// Host adapter model: sends register frames and link reset requests.
// Assumes the bench calls its tasks; it drives at the falling clock edge.
`timescale 1ns/1ps
`default_nettype none
module stf_host_model
   import stf_pkg::*;
(
   // Clock
   input  wire logic          clk,
   // Frame side
   output var  logic          frameValid,
   output var  stf_frame_type frame,
   output var  logic          comResetReq
);
   // ==================================================================
   // Shadow copy of soft reset, idle lines
   logic softReset = 1'h0;
   initial begin
      frameValid = 1'h0;
      frame = '0;
      comResetReq = 1'h0;
   end
   // One frame: parameters travel with the code
   task automatic send(input logic c, input logic [7:0] code, input logic [15:0] lim,
                       input logic [7:0] ctl);
      @(negedge clk);
      frame = '{c, code, 8'h00, 8'h01, lim, ctl};
      frameValid = 1'h1;
      @(negedge clk);
      frameValid = 1'h0;
      frame = ~frame; // Released lines do not hold
   endtask
   task automatic cmd(input logic [7:0] code, input logic [15:0] lim);
      send(1'h1, code, lim, 8'h08);
   endtask
   // Control write sent only on a soft reset change
   task automatic ctl(input logic rst);
      if (rst !== softReset) begin
         softReset = rst;
         send(1'h0, 8'h00, 16'h0000, {4'h0, 1'h1, rst, 2'h0});
      end
   endtask
   task automatic link_reset();
      @(negedge clk);
      comResetReq = 1'h1;
      @(negedge clk);
      comResetReq = 1'h0;
   endtask
endmodule // stf_host_model
`default_nettype wire

// ===== sim/testbench.sv
// Testbench of the task-file front end: host model, drive state, reads.
// Assumes the design package; the ms tick is shortened to 4 cycles.
`timescale 1ns/1ps
`default_nettype none
module testbench
   import stf_pkg::*;
;
   // ==================================================================
   // Signals and instances
   logic clk, sys_rst, frameValid, comResetReq, comInit, cmdStart, intPending, seen;
   logic standbyMode, spinReady, securityLocked, lowPowerModel, driveFault, seekDone;
   logic dataRequest, correctedData, indexPulse, mediaDone, mediaError, rdEn;
   stf_frame_type frame;
   logic [1:0]  rdSel;
   logic [7:0]  readData, status, errorOut, cmdCode;
   logic [15:0] effLimitMs, mn, lim;
   int n_fail = 0, n_compared = 0, cyc = 0;
   stf_front_end #(.MS_CYCLES(4)) dut (.clk, .sys_rst, .frameValid, .frame, .comResetReq,
      .comInit, .standbyMode, .spinReady, .securityLocked, .lowPowerModel, .driveFault,
      .seekDone, .dataRequest, .correctedData, .indexPulse, .cmdStart, .cmdCode,
      .effLimitMs, .mediaDone, .mediaError, .rdEn, .rdSel, .readData, .status,
      .sectorCountOut(), .errorOut, .intPending);
   stf_host_model host (.clk, .frameValid, .frame, .comResetReq);
   initial begin
      clk = 1'h0;
      forever #12.5 clk = ~clk;
   end
   // Hang guard
   always @(posedge clk) begin
      cyc++;
      if (cyc == 10000) begin
         n_fail++;
         wrap_up();
      end
   end
   // ==================================================================
   // Tasks
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_compared++;
      if (got !== exp) begin
         n_fail++;
         $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic rd(input logic [1:0] sel);
      @(negedge clk);
      rdEn = 1'h1;
      rdSel = sel;
      @(negedge clk);
      rdEn = 1'h0;
      @(negedge clk);
   endtask
   // Watch for a start pulse or a link reset reply
   task automatic poll(input logic link, input int n);
      seen = 1'h0;
      repeat (n) begin
         seen |= link ? comInit : cmdStart;
         @(negedge clk);
      end
   endtask
   task automatic done();
      mediaDone = 1'h1;
      @(negedge clk);
      mediaDone = 1'h0;
      repeat (2) @(negedge clk);
      chk(status[STF_ST_BUSY], 1'h0);
   endtask
   task automatic run(input logic [7:0] code, input logic [15:0] l, input logic ab,
                      input logic [15:0] exp);
      host.cmd(code, l);
      poll(1'h0, 4);
      chk(seen, !ab);
      if (ab) begin
         chk(errorOut, STF_ERR_ABORT);
         chk(status[STF_ST_ERR], 1'h1);
         chk(status[STF_ST_BUSY], 1'h0);
      end else begin
         chk(effLimitMs, exp);
         done();
      end
   endtask
   task automatic wrap_up();
      $display("Comparisons %0d, mismatches %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   // ==================================================================
   // Main sequence
   initial begin
      sys_rst = 1'h1;
      {standbyMode, spinReady, securityLocked, lowPowerModel} = 4'h4;
      {driveFault, seekDone, dataRequest, correctedData, indexPulse} = 5'h00;
      {mediaDone, mediaError, rdEn, rdSel} = 5'h00;
      repeat (12) @(negedge clk);
      sys_rst = 1'h0;
      @(negedge clk);
      chk(errorOut, STF_ERR_DIAG_OK);
      chk(status, 8'h40);
      host.cmd(STF_CMD_CHECK_POWER, 16'h0000);
      rd(STF_SEL_SECT_CNT);
      chk(readData, STF_PWR_IDLE);
      securityLocked = 1'h1;
      run(STF_CMD_DOWNLOAD, 16'h0000, 1'h1, 16'h0000);
      securityLocked = 1'h0;
      {driveFault, dataRequest} = 2'h3;
      rd(STF_SEL_ALT_STATUS);
      chk(readData, 8'h69);
      chk(intPending, 1'h1);
      rd(STF_SEL_STATUS);
      chk(readData, 8'h69);
      chk(intPending, 1'h0);
      {driveFault, dataRequest} = 2'h0;
      // Floors just below and at the minimum, both model kinds
      for (int i = 0; i < 8; i++) begin
         lowPowerModel = i[1];
         mn = i[2] ? 16'(i[1] ? STF_RECOV_MIN_LP_MS : STF_RECOV_MIN_MS)
                   : 16'(i[1] ? STF_STREAM_MIN_LP_MS : STF_STREAM_MIN_MS);
         lim = i[0] ? mn : mn - 16'h0001;
         if (i[2]) run(STF_CMD_SCT_RECOVERY, lim, !i[0], lim);
         else run(i[0] ? STF_CMD_WRITE_STREAM : STF_CMD_READ_STREAM, lim, 1'h0, mn);
      end
      // Plain command: starts at once, code handed on, media error reported
      host.cmd(8'h20, 16'h0000);
      poll(1'h0, 4);
      chk(seen, 1'h1);
      chk(cmdCode, 8'h20);
      mediaError = 1'h1;
      done();
      mediaError = 1'h0;
      chk(status[STF_ST_ERR], 1'h1);
      // Standby: start waits for spin-up, past the limit for the streaming command only
      {lowPowerModel, standbyMode, spinReady} = 3'h2;
      host.cmd(STF_CMD_CHECK_POWER, 16'h0000);
      rd(STF_SEL_SECT_CNT);
      chk(readData, STF_PWR_STANDBY);
      for (int i = 0; i < 2; i++) begin
         host.cmd(i ? STF_CMD_SCT_RECOVERY : STF_CMD_READ_STREAM, i ? 16'h1964 : 16'h0032);
         poll(1'h0, 260);
         chk(seen, 1'h0);
         chk(status[STF_ST_BUSY], 1'h1);
         spinReady = 1'h1;
         poll(1'h0, 4);
         chk(seen, 1'h1);
         done();
         spinReady = 1'h0;
      end
      {standbyMode, spinReady} = 2'h1;
      host.ctl(1'h1);
      host.ctl(1'h1);
      repeat (3) @(negedge clk);
      chk(status[STF_ST_READY], 1'h0);
      host.ctl(1'h0);
      repeat (3) @(negedge clk);
      chk(status[STF_ST_READY], 1'h1);
      host.link_reset();
      poll(1'h1, 20);
      chk(seen, 1'h0);
      poll(1'h1, 2100);
      chk(seen, 1'h1);
      host.link_reset();
      poll(1'h1, 3);
      chk(seen, 1'h1);
      wrap_up();
   end
endmodule // testbench
`default_nettype wire
